/* hdl/rpi_async_fifo.sv */
/*
 * two-entry dual-clock buffer with gray-coded pointers.
 * assumes the reader and writer each keep their own valid/ready rules.
 */
`timescale 1ns/10ps
`default_nettype none

module rpi_async_fifo #(
    parameter int W = 6
) (
    input wire logic i_wr_clk,
    input wire logic i_rd_clk,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [W-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [W-1:0] o_rd_data
);

    // ------------------------------------------------------------------
    // pointers: 2-bit gray counters, 00 01 11 10
    // ------------------------------------------------------------------
    logic [1:0] wr_gray;
    logic [1:0] rd_gray;
    logic [1:0] rd_gray_at_wr;
    logic [1:0] wr_gray_at_rd;
    logic [W-1:0] mem [2];
    wire wr_addr = wr_gray[1] ^ wr_gray[0];
    wire rd_addr = rd_gray[1] ^ rd_gray[0];
    wire push = i_wr_valid & o_wr_ready;
    wire pop = o_rd_valid & i_rd_ready;

    // full when writer has lapped reader by the depth
    assign o_wr_ready = (wr_gray != ~rd_gray_at_wr);
    assign o_rd_valid = (rd_gray != wr_gray_at_rd);
    assign o_rd_data = mem[rd_addr];

    rpi_sync2 #(.W(2)) u_rd_to_wr (
        .i_clk(i_wr_clk),
        .i_rst(i_rst),
        .i_async(rd_gray),
        .o_sync(rd_gray_at_wr)
    );

    rpi_sync2 #(.W(2)) u_wr_to_rd (
        .i_clk(i_rd_clk),
        .i_rst(i_rst),
        .i_async(wr_gray),
        .o_sync(wr_gray_at_rd)
    );

    always_ff @(posedge i_wr_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_gray <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_addr] <= i_wr_data;
            wr_gray <= {wr_gray[0], ~wr_gray[1]};
        end
    end

    always_ff @(posedge i_rd_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_gray <= 2'h0;
        end else if (pop) begin
            rd_gray <= {rd_gray[0], ~rd_gray[1]};
        end
    end

endmodule : rpi_async_fifo

`default_nettype wire

/* hdl/rpi_defs.svh */
/*
 * constants of the repeater phy port interface: widths, counts, codes.
 * assumes inclusion by bare name from the package and the top module.
 */
`ifndef RPI_DEFS_SVH
`define RPI_DEFS_SVH

// ----------------------------------------------------------------------
// widths, counts and codes
// ----------------------------------------------------------------------
`define RPI_PORTS 12
`define RPI_IDX_W 4
`define RPI_NIB_W 4
`define RPI_WORD_W 6
`define RPI_SYNC_STAGES 2
`define RPI_PORT_NONE 4'hf
`define RPI_PORT_ONE 12'h001
`define RPI_MASK_ZERO 12'h000
`define RPI_NIB_ZERO 4'h0

`endif

/* hdl/rpi_phy_port.sv */
/*
 * phy-side port logic of a twelve-port repeater: receive enable selection,
 * receive nibble capture on the phy receive clock, hand-off of receive words
 * toward the inter-repeater bus, and the shared transmit nibble path.
 * assumes up to twelve phy chips share one receive and one transmit bus,
 * that the phy receive clock is unrelated to i_clk and may stop when idle.
 */
// Overview of operation
// - receive enable polarity follows the strap: open or high is active high.
// - one receive enable output per phy gates its outputs onto the shared bus.
// - a 4-bit nibble from the shared bus is taken from the enabled phy.
// - receive error and its code go only to the inter-repeater bus.
// - a receive path is enabled only while that port's carrier is present; with the strap low all twelve are enabled in reset and 3 i_clk cycles after.
// - phy launches on the falling receive clock edge; capture uses that clock.
// - all twelve carrier inputs are asynchronous and synchronised first.
// - a high transmit enable makes that phy send the shared transmit nibble.
// - transmit in progress is the or of all transmit enables.
// - transmit error is high for each nibble carrying a code violation.
// - one 4-bit transmit nibble is common to every enabled phy.
// - receive error crosses to the repeater bus as an active-low line.
// - inverted data valid crosses to the repeater bus, framing good packets.
`include "rpi_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module rpi_phy_port
    import rpi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_phy_receive_clock,
    input wire logic i_receive_enable_polarity_strap,
    input wire logic [`RPI_PORTS-1:0] i_carrier_sense,
    input wire logic [`RPI_NIB_W-1:0] i_rx_data,
    input wire logic i_rx_data_valid,
    input wire logic i_rx_error,
    input wire logic i_repeater_bus_ready,
    input wire logic [`RPI_PORTS-1:0] i_tx_port_mask,
    input wire logic [`RPI_NIB_W-1:0] i_tx_data,
    input wire logic i_tx_error,
    output logic [`RPI_PORTS-1:0] o_port_receive_enable,
    output logic [`RPI_IDX_W-1:0] o_rx_port_index,
    output logic o_rx_port_active,
    output logic o_rx_collision,
    output logic o_rx_buffer_ready,
    output logic [`RPI_NIB_W-1:0] o_repeater_bus_data,
    output logic o_repeater_bus_valid_n,
    output logic o_repeater_bus_error_n,
    output logic o_repeater_bus_strobe,
    output logic [`RPI_PORTS-1:0] o_port_transmit_enable,
    output logic o_tx_in_progress,
    output logic [`RPI_NIB_W-1:0] o_tx_data,
    output logic o_tx_error
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // lowest-numbered set port, or none
    function automatic rpi_idx_t rpi_lowest(input rpi_mask_t mask);
        rpi_idx_t idx;
        idx = `RPI_PORT_NONE;
        for (int i = `RPI_PORTS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                idx = rpi_idx_t'(i);
            end
        end
        return idx;
    endfunction : rpi_lowest

    // one-hot mask of a port index
    function automatic rpi_mask_t rpi_onehot(input rpi_idx_t idx);
        rpi_mask_t mask;
        mask = `RPI_MASK_ZERO;
        if (idx < rpi_idx_t'(`RPI_PORTS)) begin
            mask = rpi_mask_t'(`RPI_PORT_ONE << idx);
        end
        return mask;
    endfunction : rpi_onehot

    // true when two or more ports are set
    function automatic logic rpi_multi(input rpi_mask_t mask);
        return (mask & (mask - rpi_mask_t'(1))) != `RPI_MASK_ZERO;
    endfunction : rpi_multi

    // ------------------------------------------------------------------
    // pin synchronisers in the core domain
    // ------------------------------------------------------------------
    rpi_mask_t carrier_sync;
    logic strap_sync;

    rpi_sync2 #(.W(`RPI_PORTS)) u_carrier_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_carrier_sense),
        .o_sync(carrier_sync)
    );

    rpi_sync2 #(.W(1)) u_strap_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_receive_enable_polarity_strap),
        .o_sync(strap_sync)
    );

    // ------------------------------------------------------------------
    // polarity strap capture
    // ------------------------------------------------------------------
    // caught once, after the synchroniser has filled; a strap is not meant to move later
    logic strap_taken;
    logic [1:0] strap_wait;
    logic enable_active_high;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            strap_wait <= 2'h0;
            strap_taken <= 1'b0;
            enable_active_high <= 1'b1;
        end else begin
            strap_wait <= {strap_wait[0], 1'b1};
            if (strap_wait[1] && !strap_taken) begin
                strap_taken <= 1'b1;
                enable_active_high <= strap_sync;
            end
        end
    end

    // ------------------------------------------------------------------
    // receive port selection
    // ------------------------------------------------------------------
    rpi_rx_state_e rx_state;
    rpi_rx_state_e next_rx_state;
    rpi_idx_t sel_port;
    rpi_idx_t next_sel_port;

    wire any_carrier = (carrier_sync != `RPI_MASK_ZERO);
    wire rpi_idx_t first_carrier = rpi_lowest(carrier_sync);
    wire sel_carrier = (rpi_onehot(sel_port) & carrier_sync) != `RPI_MASK_ZERO;
    wire collision = rpi_multi(carrier_sync);

    // a locked port keeps the bus until its own carrier drops, so a later
    // port can never cut into a frame; other ports wait one idle cycle
    always_comb begin
        next_rx_state = rx_state;
        next_sel_port = sel_port;
        unique case (rx_state)
            RPI_RX_IDLE: begin
                if (any_carrier) begin
                    next_rx_state = RPI_RX_LOCKED;
                    next_sel_port = first_carrier;
                end
            end
            RPI_RX_LOCKED: begin
                if (!sel_carrier) begin
                    next_rx_state = RPI_RX_IDLE;
                    next_sel_port = `RPI_PORT_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_state <= RPI_RX_IDLE;
            sel_port <= `RPI_PORT_NONE;
        end else begin
            rx_state <= next_rx_state;
            sel_port <= next_sel_port;
        end
    end

    // ------------------------------------------------------------------
    // receive enable outputs
    // ------------------------------------------------------------------
    wire next_rx_active = (next_rx_state == RPI_RX_LOCKED);
    wire rpi_mask_t next_enable_mask = next_rx_active ? rpi_onehot(next_sel_port)
                                                      : `RPI_MASK_ZERO;
    wire rpi_mask_t next_enable_pins = next_enable_mask ^ {`RPI_PORTS{~enable_active_high}};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_receive_enable <= `RPI_MASK_ZERO;
            o_rx_port_index <= `RPI_PORT_NONE;
            o_rx_port_active <= 1'b0;
            o_rx_collision <= 1'b0;
        end else begin
            o_port_receive_enable <= next_enable_pins;
            o_rx_port_index <= next_sel_port;
            o_rx_port_active <= next_rx_active;
            o_rx_collision <= collision;
        end
    end

    // ------------------------------------------------------------------
    // receive capture on the phy clock
    // ------------------------------------------------------------------
    // the phy launches on the falling edge, so the rising edge sits mid-eye
    logic rx_active_at_rx;
    rpi_nib_t rx_nib;
    logic rx_dv;
    logic rx_er;
    logic rx_cap_valid;
    logic wr_ready;

    rpi_sync2 #(.W(1)) u_active_to_rx (
        .i_clk(i_phy_receive_clock),
        .i_rst(i_rst),
        .i_async(o_rx_port_active),
        .o_sync(rx_active_at_rx)
    );

    always_ff @(posedge i_phy_receive_clock or posedge i_rst) begin
        if (i_rst) begin
            rx_nib <= `RPI_NIB_ZERO;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rx_cap_valid <= 1'b0;
        end else begin
            rx_nib <= i_rx_data;
            rx_dv <= i_rx_data_valid;
            rx_er <= i_rx_error;
            rx_cap_valid <= rx_active_at_rx;
        end
    end

    // words carry valid or error; idle nibbles are not buffered.
    // the phy cannot stall, so a word offered while full is lost;
    // o_rx_buffer_ready shows that
    wire rx_word_present = rx_cap_valid & (rx_dv | rx_er);
    wire rpi_word_t rx_word = {rx_er, rx_dv, rx_nib};

    // held word stands a whole phy period while its toggle crosses;
    // relies on i_clk running several times faster than the phy clock
    rpi_word_t rx_hold;
    logic rx_toggle;
    logic toggle_sync;
    logic toggle_seen;

    always_ff @(posedge i_phy_receive_clock or posedge i_rst) begin
        if (i_rst) begin
            rx_hold <= '0;
            rx_toggle <= 1'b0;
        end else if (rx_word_present) begin
            rx_hold <= rx_word;
            rx_toggle <= ~rx_toggle;
        end
    end

    rpi_sync2 #(.W(1)) u_toggle_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(rx_toggle),
        .o_sync(toggle_sync)
    );

    wire new_word = toggle_sync ^ toggle_seen;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            toggle_seen <= 1'b0;
            o_rx_buffer_ready <= 1'b0;
        end else begin
            toggle_seen <= toggle_sync;
            o_rx_buffer_ready <= wr_ready;
        end
    end

    // ------------------------------------------------------------------
    // receive word buffer
    // ------------------------------------------------------------------
    logic rd_valid;
    rpi_word_t rd_word;
    logic out_busy;
    wire pop = rd_valid & (~out_busy | i_repeater_bus_ready);

    rpi_async_fifo #(.W(`RPI_WORD_W)) u_rx_fifo (
        .i_wr_clk(i_clk),
        .i_rd_clk(i_clk),
        .i_rst(i_rst),
        .i_wr_valid(new_word),
        .o_wr_ready(wr_ready),
        .i_wr_data(rx_hold),
        .o_rd_valid(rd_valid),
        .i_rd_ready(pop),
        .o_rd_data(rd_word)
    );

    // ------------------------------------------------------------------
    // inter-repeater bus side
    // ------------------------------------------------------------------
    // error and code go out here and nowhere else in the block
    wire rd_er = rd_word[`RPI_WORD_W-1];
    wire rd_dv = rd_word[`RPI_WORD_W-2];
    wire rpi_nib_t rd_nib = rd_word[`RPI_NIB_W-1:0];
    wire drop_word = out_busy & i_repeater_bus_ready & ~rd_valid;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_busy <= 1'b0;
            o_repeater_bus_strobe <= 1'b0;
            o_repeater_bus_data <= `RPI_NIB_ZERO;
            o_repeater_bus_valid_n <= 1'b1;
            o_repeater_bus_error_n <= 1'b1;
        end else if (pop) begin
            out_busy <= 1'b1;
            o_repeater_bus_strobe <= 1'b1;
            o_repeater_bus_data <= rd_nib;
            o_repeater_bus_valid_n <= ~rd_dv;
            o_repeater_bus_error_n <= ~rd_er;
        end else if (drop_word) begin
            out_busy <= 1'b0;
            o_repeater_bus_strobe <= 1'b0;
            o_repeater_bus_valid_n <= 1'b1;
            o_repeater_bus_error_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------
    // enables, nibble and error are registered together so every phy
    // sees the same nibble in the same cycle as its enable
    wire next_tx_busy = (i_tx_port_mask != `RPI_MASK_ZERO);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_transmit_enable <= `RPI_MASK_ZERO;
            o_tx_in_progress <= 1'b0;
            o_tx_data <= `RPI_NIB_ZERO;
            o_tx_error <= 1'b0;
        end else begin
            o_port_transmit_enable <= i_tx_port_mask;
            o_tx_in_progress <= next_tx_busy;
            o_tx_data <= i_tx_data;
            o_tx_error <= i_tx_error;
        end
    end

endmodule : rpi_phy_port

`default_nettype wire

/* hdl/rpi_pkg.sv */
/*
 * types of the repeater phy port interface.
 * assumes rpi_defs.svh on the include path.
 */
`include "rpi_defs.svh"

package rpi_pkg;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef logic [`RPI_PORTS-1:0] rpi_mask_t;
    typedef logic [`RPI_IDX_W-1:0] rpi_idx_t;
    typedef logic [`RPI_NIB_W-1:0] rpi_nib_t;
    typedef logic [`RPI_WORD_W-1:0] rpi_word_t;

    typedef enum logic [0:0] {
        RPI_RX_IDLE = 1'b0,
        RPI_RX_LOCKED = 1'b1
    } rpi_rx_state_e;

endpackage : rpi_pkg

/* hdl/rpi_sync2.sv */
/*
 * two flip-flop level synchroniser, one bit per lane.
 * assumes each lane is a level that stays put for several destination clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module rpi_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // first stage feeds only the second stage
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule : rpi_sync2

`default_nettype wire

/* verification/rpi_chk.sv */
/* assertions on the ports of rpi_phy_port.
   assumes the strap only changes while reset is held. */
`timescale 1ns/10ps
`default_nettype none
module rpi_chk
    import rpi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_receive_enable_polarity_strap,
    input wire rpi_mask_t i_carrier_sense,
    input wire rpi_mask_t i_tx_port_mask,
    input wire rpi_nib_t i_tx_data,
    input wire logic i_tx_error,
    input wire logic i_repeater_bus_ready,
    input wire rpi_mask_t o_port_receive_enable,
    input wire rpi_idx_t o_rx_port_index,
    input wire logic o_rx_port_active,
    input wire logic o_rx_collision,
    input wire rpi_nib_t o_repeater_bus_data,
    input wire logic o_repeater_bus_valid_n,
    input wire logic o_repeater_bus_error_n,
    input wire logic o_repeater_bus_strobe,
    input wire rpi_mask_t o_port_transmit_enable,
    input wire logic o_tx_in_progress,
    input wire rpi_nib_t o_tx_data,
    input wire logic o_tx_error
);
// ---------------------------------------------------------------
// helpers
// ---------------------------------------------------------------
logic [3:0] settle;
rpi_mask_t cs1, cs2, cs3;
wire logic ok = (settle == 4'h4);
wire rpi_mask_t en_act = i_receive_enable_polarity_strap ? o_port_receive_enable
                                                         : ~o_port_receive_enable;
// carrier delayed 3 edges: 2 sync flops plus the select register
always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        {settle, cs1, cs2, cs3} <= '0;
    end else begin
        settle <= ok ? settle : settle + 4'h1;
        {cs1, cs2, cs3} <= {i_carrier_sense, cs1, cs2};
    end
end
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
// ---------------------------------------------------------------
// properties
// ---------------------------------------------------------------
property p_one; ok |-> $onehot0(en_act); endproperty
a_one: assert property (p_one) else $error("several receive enables");
property p_sel; o_rx_port_active |-> en_act == (12'h001 << o_rx_port_index); endproperty
a_sel: assert property (p_sel) else $error("enable not at index");
property p_idle; ok && !o_rx_port_active |-> en_act == 12'h000 && o_rx_port_index == 4'hf;
endproperty
a_idle: assert property (p_idle) else $error("enable without port");
property p_crs; o_rx_port_active |-> cs3[o_rx_port_index]; endproperty
a_crs: assert property (p_crs) else $error("enable without carrier");
property p_low;
    $rose(o_rx_port_active) |-> (cs3 & ((12'h001 << o_rx_port_index) - 12'h001)) == 12'h000;
endproperty
a_low: assert property (p_low) else $error("not lowest carrier");
property p_col; o_rx_collision == ($countones(cs3) > 1); endproperty
a_col: assert property (p_col) else $error("collision flag wrong");
property p_tx;
    ok |-> o_port_transmit_enable == $past(i_tx_port_mask) && o_tx_data == $past(i_tx_data)
        && o_tx_error == $past(i_tx_error);
endproperty
a_tx: assert property (p_tx) else $error("transmit path wrong");
property p_rdy; o_tx_in_progress == (|o_port_transmit_enable); endproperty
a_rdy: assert property (p_rdy) else $error("in progress not or");
property p_hold;
    o_repeater_bus_strobe && !i_repeater_bus_ready |=> o_repeater_bus_strobe
        && $stable(o_repeater_bus_data) && $stable(o_repeater_bus_valid_n)
        && $stable(o_repeater_bus_error_n);
endproperty
a_hold: assert property (p_hold) else $error("word lost in stall");
property p_none; !o_repeater_bus_strobe |-> o_repeater_bus_valid_n && o_repeater_bus_error_n;
endproperty
a_none: assert property (p_none) else $error("idle bus not high");
property p_word; o_repeater_bus_strobe |-> !(o_repeater_bus_valid_n && o_repeater_bus_error_n);
endproperty
a_word: assert property (p_word) else $error("empty word sent");
c_sel: cover property ($rose(o_rx_port_active));
c_col: cover property (o_rx_collision);
c_stall: cover property ((o_repeater_bus_strobe && !i_repeater_bus_ready) [*2]);
endmodule : rpi_chk
bind rpi_phy_port rpi_chk u_chk (.i_clk, .i_rst, .i_receive_enable_polarity_strap,
    .i_carrier_sense, .i_tx_port_mask, .i_tx_data, .i_tx_error, .i_repeater_bus_ready,
    .o_port_receive_enable, .o_rx_port_index, .o_rx_port_active, .o_rx_collision,
    .o_repeater_bus_data, .o_repeater_bus_valid_n, .o_repeater_bus_error_n,
    .o_repeater_bus_strobe, .o_port_transmit_enable, .o_tx_in_progress, .o_tx_data,
    .o_tx_error);
`default_nettype wire

/* verification/rpi_phy_model.sv */
/* twelve phy chips on the shared receive bus.
   assumes the bench calls word() once per nibble; clock still otherwise. */
`timescale 1ns/10ps
`default_nettype none
module rpi_phy_model
    import rpi_pkg::*;
(
    input wire logic i_strap,
    input wire rpi_mask_t i_port_receive_enable,
    output logic o_phy_receive_clock,
    output logic [3:0] o_rx_data,
    output logic o_rx_data_valid,
    output logic o_rx_error
);
// ---------------------------------------------------------------
// bus drive
// ---------------------------------------------------------------
rpi_nib_t nib;
logic dv;
logic er;
wire rpi_mask_t en_act = i_strap ? i_port_receive_enable : ~i_port_receive_enable;
wire logic drv = |en_act;
// released bus: data pulled up, valid and error pulled down
assign o_rx_data = drv ? nib : 4'hf;
assign o_rx_data_valid = drv & dv;
assign o_rx_error = drv & er;
initial begin
    o_phy_receive_clock = 1'b0;
    {nib, dv, er} = '0;
end
// launch at the falling edge, half a period before capture
task automatic word(input rpi_nib_t n, input logic v, input logic e);
    {nib, dv, er} = {n, v, e};
    #24 o_phy_receive_clock = 1'b1;
    #24 o_phy_receive_clock = 1'b0;
endtask : word
endmodule : rpi_phy_model
`default_nettype wire

/* verification/rpi_phy_port_tb.sv */
/* self-checking bench of rpi_phy_port with the phy model.
   assumes the checker is bound from its own file. */
`timescale 1ns/10ps
`default_nettype none
module rpi_phy_port_tb
    import rpi_pkg::*;
;
logic i_clk = 0, i_rst = 1, i_receive_enable_polarity_strap = 1, i_repeater_bus_ready = 1;
logic i_tx_error = 0, i_phy_receive_clock, i_rx_data_valid, i_rx_error, o_rx_port_active;
logic o_rx_collision, o_rx_buffer_ready, o_repeater_bus_valid_n, o_repeater_bus_error_n;
logic o_repeater_bus_strobe, o_tx_in_progress, o_tx_error, full_seen;
rpi_mask_t i_carrier_sense = 0, i_tx_port_mask = 0, o_port_receive_enable;
rpi_mask_t o_port_transmit_enable;
rpi_nib_t i_tx_data = 0, i_rx_data, o_repeater_bus_data, o_tx_data;
rpi_idx_t o_rx_port_index;
rpi_word_t got[$], exp[$];
int mismatches = 0, checks_done = 0;
typedef struct {rpi_mask_t m; rpi_nib_t d; logic e; logic busy;} rpi_tx_row_s;
rpi_tx_row_s rows[4] = '{'{12'h000, 4'h0, 1'b0, 1'b0}, '{12'h800, 4'ha, 1'b0, 1'b1},
                         '{12'hfff, 4'h5, 1'b1, 1'b1}, '{12'h001, 4'hf, 1'b1, 1'b1}};
always #2 i_clk = ~i_clk;
rpi_phy_port DUT (.i_clk, .i_rst, .i_phy_receive_clock, .i_receive_enable_polarity_strap,
    .i_carrier_sense, .i_rx_data, .i_rx_data_valid, .i_rx_error, .i_repeater_bus_ready,
    .i_tx_port_mask, .i_tx_data, .i_tx_error, .o_port_receive_enable, .o_rx_port_index,
    .o_rx_port_active, .o_rx_collision, .o_rx_buffer_ready, .o_repeater_bus_data,
    .o_repeater_bus_valid_n, .o_repeater_bus_error_n, .o_repeater_bus_strobe,
    .o_port_transmit_enable, .o_tx_in_progress, .o_tx_data, .o_tx_error);
rpi_phy_model u_phy (.i_strap(i_receive_enable_polarity_strap),
    .i_port_receive_enable(o_port_receive_enable), .o_phy_receive_clock(i_phy_receive_clock),
    .o_rx_data(i_rx_data), .o_rx_data_valid(i_rx_data_valid), .o_rx_error(i_rx_error));
// ---------------------------------------------------------------
// tasks
// ---------------------------------------------------------------
task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
endtask : check
task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask : print_verdict
task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
endtask : tick
task automatic send(input rpi_nib_t n, input logic v, input logic e);
    u_phy.word(n, v, e);
    if (v | e) exp.push_back({~e, ~v, n});
endtask : send
// phy clock offset from the core clock so the two stay unrelated
task automatic frame(input rpi_nib_t n);
    #1.3;
    repeat (3) send(4'h0, 1'b0, 1'b0);
    send(n, 1'b1, 1'b0);
endtask : frame
task automatic flush();
    repeat (2) send(4'h0, 1'b0, 1'b0);
    tick(30);
    check("word_count", 16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check("word", 16'(got[i]), 16'(exp[i]));
    got = {};
    exp = {};
endtask : flush
task automatic do_reset(input logic s);
    {i_rst, i_receive_enable_polarity_strap, i_carrier_sense} = {1'b1, s, 12'h000};
    tick(6);
    i_rst = 1'b0;
    tick(4);
endtask : do_reset
always @(posedge i_clk) begin
    if (!i_rst && o_repeater_bus_strobe && i_repeater_bus_ready)
        got.push_back({o_repeater_bus_error_n, o_repeater_bus_valid_n, o_repeater_bus_data});
end
initial begin
    #200000;
    mismatches++;
    print_verdict();
end
// ---------------------------------------------------------------
// sequence
// ---------------------------------------------------------------
initial begin
    do_reset(1'b1);
    check("idle_index", o_rx_port_index, 4'hf);
    check("idle_strobe", {o_repeater_bus_strobe, o_repeater_bus_valid_n}, 2'b01);
    foreach (rows[i]) begin
        {i_tx_port_mask, i_tx_data, i_tx_error} = {rows[i].m, rows[i].d, rows[i].e};
        tick(1);
        check("tx_enable", o_port_transmit_enable, rows[i].m);
        check("tx_busy", o_tx_in_progress, rows[i].busy);
        check("tx_nibble", {o_tx_error, o_tx_data}, {rows[i].e, rows[i].d});
    end
    i_carrier_sense = 12'h020;
    tick(2);
    check("sync_delay", o_rx_port_active, 1'b0);
    tick(1);
    check("rx_enable", o_port_receive_enable, 12'h020);
    i_carrier_sense = 12'h024;
    tick(3);
    check("locked_index", {o_rx_collision, o_rx_port_index}, 5'h15);
    frame(4'ha);
    send(4'h5, 1'b1, 1'b0);
    send(4'h0, 1'b1, 1'b1);
    send(4'h2, 1'b0, 1'b1);
    flush();
    full_seen = 1'b0;
    i_repeater_bus_ready = 1'b0;
    frame(4'h1);
    for (int k = 2; k < 7; k++) begin
        send(rpi_nib_t'(k), 1'b1, 1'b0);
        full_seen |= !o_rx_buffer_ready;
    end
    repeat (2) send(4'h0, 1'b0, 1'b0);
    tick(1);
    i_repeater_bus_ready = 1'b1;
    tick(30);
    check("buffer_full", full_seen, 1'b1);
    check("dropped", got.size() < exp.size(), 1'b1);
    check("first_word", 16'(got[0]), 16'(exp[0]));
    check("second_word", 16'(got[1]), 16'(exp[1]));
    got = {};
    exp = {};
    i_carrier_sense = 12'h004;
    tick(3);
    check("release", {o_rx_port_active, o_port_receive_enable}, 13'h0000);
    tick(1);
    check("next_port", {o_rx_port_index, o_port_receive_enable}, 16'h2004);
    do_reset(1'b0);
    check("low_idle", o_port_receive_enable, 12'hfff);
    i_carrier_sense = 12'h800;
    tick(3);
    check("low_enable", o_port_receive_enable, 12'h7ff);
    frame(4'h9);
    flush();
    i_carrier_sense = 12'h000;
    tick(5);
    check("final_idle", o_rx_port_active, 1'b0);
    print_verdict();
end
endmodule : rpi_phy_port_tb
`default_nettype wire
